// *** pkg/ssp_cfg.svh ***
// Addresses, command values and counts for the sensor serial port
// Included by the port logic and its pixel store
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_DIR_BIT 7
`define SSP_ADDR_DATA_OUT_LO 7'h0C
`define SSP_ADDR_DATA_OUT_HI 7'h0D
`define SSP_ADDR_FRAME_CAPTURE 7'h13
`define SSP_ADDR_FW_ENABLE 7'h14
`define SSP_ADDR_FW_VERSION 7'h1F
`define SSP_ADDR_PIXEL_BURST 7'h40
`define SSP_ADDR_MOTION_BURST 7'h50
`define SSP_ADDR_LOAD_PORT 7'h60
`define SSP_FW_STAGE1 8'h1D
`define SSP_FW_ARM 8'h18
`define SSP_FW_CRC_CMD 8'h15
`define SSP_FW_BYTES 11'h7C2
`define SSP_PIX_BYTES 11'h600
`define SSP_PIX_SPLIT 11'h384
`define SSP_IDX_MAX 11'h7FF
`define SSP_BIT_FIRST 3'h0
`define SSP_BIT_LAST 3'h7
`define SSP_SYNC_RST 5'h06
`define SSP_CRC_POLY 16'h1021
`define SSP_CRC_INIT 16'hFFFF
`define SSP_MEM_AW 11
`endif

// *** pkg/ssp_pkg.sv ***
// Types shared by the sensor serial port and its pixel store
// Assumes ssp_cfg.svh for field widths
`include "ssp_cfg.svh"
package ssp_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WDATA = 6'h02,
        ST_RDATA = 6'h04,
        ST_MBURST = 6'h08,
        ST_PBURST = 6'h10,
        ST_LBURST = 6'h20
    } port_state_e;
    typedef struct packed {
        logic valid;
        logic frame_start;
        logic [5:0] value;
    } pixel_s;
    typedef struct packed {
        logic [7:0] motion;
        logic [7:0] delta_x;
        logic [7:0] delta_y;
        logic [7:0] surface_quality;
        logic [7:0] shutter_hi;
        logic [7:0] shutter_lo;
        logic [7:0] peak_pixel;
    } motion_s;
    typedef struct packed {
        logic we;
        logic [`SSP_MEM_AW-1:0] addr;
        logic [7:0] data;
    } mem_wr_s;
endpackage

// *** core/pixel_store.sv ***
// Byte store shared by the firmware image and captured pixels
// Assumes one write and one registered read per clock
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module pixel_store (
    input wire logic clk_in,
    input wire ssp_pkg::mem_wr_s wr_in,
    input wire logic [`SSP_MEM_AW-1:0] raddr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_reg [0:(1<<`SSP_MEM_AW)-1];

    always_ff @(posedge clk_in) begin
        if (wr_in.we) begin
            mem_reg[wr_in.addr] <= wr_in.data;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_out <= mem_reg[raddr_in];
    end
endmodule

// *** core/sensor_serial_port_burst.sv ***
// Slave serial port with motion, firmware load and pixel capture bursts
// Assumes SCLK_IN idles high and only toggles while chip select is low
`timescale 1ns/100ps
`include "ssp_cfg.svh"

module sensor_serial_port_burst #(
    parameter logic [7:0] FW_VERSION_ID = 8'h00 // Arbitrary value
) (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic SCLK_IN,
    input wire logic CHIP_SELECT_N_IN,
    input wire logic MOSI_IN,
    output logic MISO_OUT,
    output logic MISO_OE_N_OUT,
    input wire logic POWER_DOWN_N_IN,
    input wire logic SENSOR_RESET_IN,
    input wire ssp_pkg::motion_s MOTION_IN,
    input wire ssp_pkg::pixel_s PIXEL_IN,
    output logic TRACKING_EN_OUT,
    output logic FW_VALID_OUT
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'h0} ^ `SSP_CRC_POLY) : {r[14:0], 1'h0};
        end
        return r;
    endfunction

    function automatic logic [7:0] motion_byte(input ssp_pkg::motion_s m, input logic [10:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            11'h000: b = m.motion;
            11'h001: b = m.delta_x;
            11'h002: b = m.delta_y;
            11'h003: b = m.surface_quality;
            11'h004: b = m.shutter_hi;
            11'h005: b = m.shutter_lo;
            11'h006: b = m.peak_pixel;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------
    // Link side, clocked by SCLK
    // ------------------------------------------------------------
    logic link_rst_n;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_shift_reg;
    logic [7:0] rx_byte_reg;
    logic rx_tgl_reg;
    logic [6:0] tx_shift_reg;
    logic miso_reg;
    logic ld_tgl_reg;
    logic [7:0] tx_word_reg;

    assign link_rst_n = RESETN_IN & ~CHIP_SELECT_N_IN & POWER_DOWN_N_IN & ~SENSOR_RESET_IN;

    always_ff @(posedge SCLK_IN or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= `SSP_BIT_FIRST;
            rx_shift_reg <= 7'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_shift_reg <= {rx_shift_reg[5:0], MOSI_IN};
        end
    end

    // Byte handoff survives chip select so the toggle stays in step
    always_ff @(posedge SCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rx_byte_reg <= 8'h00;
            rx_tgl_reg <= 1'h0;
        end else if (link_rst_n && bit_cnt_reg == `SSP_BIT_LAST) begin
            rx_byte_reg <= {rx_shift_reg, MOSI_IN};
            rx_tgl_reg <= ~rx_tgl_reg;
        end
    end

    always_ff @(negedge SCLK_IN or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_shift_reg <= 7'h00;
            miso_reg <= 1'h0;
        end else if (bit_cnt_reg == `SSP_BIT_FIRST) begin
            miso_reg <= tx_word_reg[7];
            tx_shift_reg <= tx_word_reg[6:0];
        end else begin
            miso_reg <= tx_shift_reg[6];
            tx_shift_reg <= {tx_shift_reg[5:0], 1'h0};
        end
    end

    always_ff @(negedge SCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ld_tgl_reg <= 1'h0;
        end else if (link_rst_n && bit_cnt_reg == `SSP_BIT_FIRST) begin
            ld_tgl_reg <= ~ld_tgl_reg;
        end
    end

    assign MISO_OUT = miso_reg;
    assign MISO_OE_N_OUT = ~link_rst_n;

    // ------------------------------------------------------------
    // Crossing into the core clock
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic rx_prev_reg;
    logic ld_prev_reg;
    logic port_off;
    logic take_byte;
    logic take_load;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sync1_reg <= `SSP_SYNC_RST;
            sync2_reg <= `SSP_SYNC_RST;
            rx_prev_reg <= 1'h0;
            ld_prev_reg <= 1'h0;
        end else begin
            sync1_reg <= {rx_tgl_reg, ld_tgl_reg, CHIP_SELECT_N_IN, POWER_DOWN_N_IN, SENSOR_RESET_IN};
            sync2_reg <= sync1_reg;
            rx_prev_reg <= sync2_reg[4];
            ld_prev_reg <= sync2_reg[3];
        end
    end

    assign port_off = sync2_reg[2] | ~sync2_reg[1] | sync2_reg[0];
    assign take_byte = (sync2_reg[4] ^ rx_prev_reg) & ~port_off;
    assign take_load = (sync2_reg[3] ^ ld_prev_reg) & ~port_off;

    // ------------------------------------------------------------
    // Transaction sequencing
    // ------------------------------------------------------------
    ssp_pkg::port_state_e state_reg;
    logic [6:0] addr_reg;
    logic [10:0] byte_idx_reg;
    logic fw_armed_reg;
    logic wr_commit;
    logic rd_addr;

    assign wr_commit = take_byte && state_reg == ssp_pkg::ST_WDATA;
    assign rd_addr = take_byte && state_reg == ssp_pkg::ST_IDLE && !rx_byte_reg[`SSP_DIR_BIT];

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_reg <= ssp_pkg::ST_IDLE;
            addr_reg <= 7'h00;
        end else if (port_off) begin
            state_reg <= ssp_pkg::ST_IDLE;
        end else if (take_byte) begin
            case (state_reg)
                ssp_pkg::ST_IDLE: begin
                    addr_reg <= rx_byte_reg[6:0];
                    if (rx_byte_reg[`SSP_DIR_BIT]) begin
                        state_reg <= (rx_byte_reg[6:0] == `SSP_ADDR_LOAD_PORT && fw_armed_reg) ?
                            ssp_pkg::ST_LBURST : ssp_pkg::ST_WDATA;
                    end else if (rx_byte_reg[6:0] == `SSP_ADDR_MOTION_BURST) begin
                        state_reg <= ssp_pkg::ST_MBURST;
                    end else if (rx_byte_reg[6:0] == `SSP_ADDR_PIXEL_BURST) begin
                        state_reg <= ssp_pkg::ST_PBURST;
                    end else begin
                        state_reg <= ssp_pkg::ST_RDATA;
                    end
                end
                ssp_pkg::ST_WDATA, ssp_pkg::ST_RDATA: state_reg <= ssp_pkg::ST_IDLE;
                default: state_reg <= state_reg;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            byte_idx_reg <= 11'h000;
        end else if (port_off) begin
            byte_idx_reg <= 11'h000;
        end else if (take_byte && byte_idx_reg != `SSP_IDX_MAX) begin
            byte_idx_reg <= byte_idx_reg + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    ssp_pkg::motion_s snap_reg;
    logic [1:0] fetch_pipe_reg;
    logic [10:0] pix_raddr_reg;
    logic [7:0] mem_rdata;
    logic [15:0] data_out_reg;
    logic cap_ready_reg;
    logic crc_busy_reg;
    logic [10:0] crc_ptr_reg;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tx_word_reg <= 8'h00;
            snap_reg <= '0;
            fetch_pipe_reg <= 2'h0;
            pix_raddr_reg <= 11'h000;
        end else begin
            fetch_pipe_reg <= {fetch_pipe_reg[0], 1'h0};
            if (rd_addr) begin
                if (rx_byte_reg[6:0] == `SSP_ADDR_MOTION_BURST) begin
                    snap_reg <= MOTION_IN;
                    tx_word_reg <= motion_byte(MOTION_IN, 11'h000);
                end else if (rx_byte_reg[6:0] == `SSP_ADDR_PIXEL_BURST) begin
                    tx_word_reg <= 8'h00;
                    pix_raddr_reg <= 11'h000;
                    fetch_pipe_reg <= {1'h0, cap_ready_reg};
                end else if (rx_byte_reg[6:0] == `SSP_ADDR_DATA_OUT_LO) begin
                    tx_word_reg <= data_out_reg[7:0];
                end else if (rx_byte_reg[6:0] == `SSP_ADDR_DATA_OUT_HI) begin
                    tx_word_reg <= data_out_reg[15:8];
                end else if (rx_byte_reg[6:0] == `SSP_ADDR_FW_VERSION) begin
                    tx_word_reg <= FW_VERSION_ID;
                end else begin
                    tx_word_reg <= 8'h00;
                end
            end else if (take_load && state_reg == ssp_pkg::ST_MBURST) begin
                tx_word_reg <= motion_byte(snap_reg, byte_idx_reg);
            end else if (take_load && state_reg == ssp_pkg::ST_PBURST) begin
                tx_word_reg <= 8'h00;
                if (cap_ready_reg && byte_idx_reg < `SSP_PIX_BYTES) begin
                    pix_raddr_reg <= byte_idx_reg;
                    fetch_pipe_reg <= 2'h1;
                end
            end else if (fetch_pipe_reg[1]) begin
                tx_word_reg <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Firmware control, tracking and image load
    // ------------------------------------------------------------
    logic fw_stage_reg;
    logic fw_valid_reg;
    logic tracking_reg;
    logic wait_reset_reg;
    logic crc_start_reg;
    logic [10:0] load_cnt_reg;
    logic load_we;
    logic load_done;
    logic cap_hit;

    assign cap_hit = wr_commit && addr_reg == `SSP_ADDR_FRAME_CAPTURE;
    assign load_we = take_byte && state_reg == ssp_pkg::ST_LBURST && load_cnt_reg < `SSP_FW_BYTES;
    assign load_done = load_we && load_cnt_reg == `SSP_FW_BYTES - 11'h001;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            load_cnt_reg <= 11'h000;
        end else if (state_reg != ssp_pkg::ST_LBURST) begin
            load_cnt_reg <= 11'h000;
        end else if (load_we) begin
            load_cnt_reg <= load_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            fw_stage_reg <= 1'h0;
            fw_armed_reg <= 1'h0;
            fw_valid_reg <= 1'h0;
            tracking_reg <= 1'h1;
            wait_reset_reg <= 1'h0;
            crc_start_reg <= 1'h0;
        end else begin
            crc_start_reg <= 1'h0;
            if (sync2_reg[0]) begin
                wait_reset_reg <= 1'h0;
                fw_stage_reg <= 1'h0;
                fw_armed_reg <= 1'h0;
            end else if (wr_commit && addr_reg == `SSP_ADDR_FW_ENABLE) begin
                if (rx_byte_reg == `SSP_FW_STAGE1) begin
                    fw_stage_reg <= 1'h1;
                end else if (rx_byte_reg == `SSP_FW_ARM && fw_stage_reg) begin
                    fw_armed_reg <= 1'h1;
                end else if (rx_byte_reg == `SSP_FW_CRC_CMD) begin
                    crc_start_reg <= 1'h1;
                end
            end
            if (load_done) begin
                fw_valid_reg <= 1'h1;
                if (!wait_reset_reg) begin
                    tracking_reg <= 1'h1;
                end
            end
            if (cap_hit) begin
                tracking_reg <= 1'h0;
                wait_reset_reg <= 1'h1;
                fw_valid_reg <= 1'h0;
                fw_armed_reg <= 1'h0;
            end
        end
    end

    assign TRACKING_EN_OUT = tracking_reg;
    assign FW_VALID_OUT = fw_valid_reg;

    // ------------------------------------------------------------
    // Frame capture into the shared store
    // ------------------------------------------------------------
    logic cap_wait_reg;
    logic cap_run_reg;
    logic [10:0] cap_cnt_reg;
    logic cap_we;
    ssp_pkg::mem_wr_s mem_wr;

    assign cap_we = PIXEL_IN.valid & ((cap_wait_reg & PIXEL_IN.frame_start) | cap_run_reg);

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cap_wait_reg <= 1'h0;
            cap_run_reg <= 1'h0;
            cap_cnt_reg <= 11'h000;
            cap_ready_reg <= 1'h0;
        end else if (cap_hit) begin
            cap_wait_reg <= 1'h1;
            cap_run_reg <= 1'h0;
            cap_cnt_reg <= 11'h000;
            cap_ready_reg <= 1'h0;
        end else if (cap_we) begin
            cap_wait_reg <= 1'h0;
            cap_cnt_reg <= cap_cnt_reg + 11'h001;
            cap_run_reg <= cap_cnt_reg != `SSP_PIX_BYTES - 11'h001;
            cap_ready_reg <= cap_cnt_reg == `SSP_PIX_BYTES - 11'h001;
        end else if (load_we) begin
            cap_ready_reg <= 1'h0;
        end
    end

    always_comb begin
        mem_wr = '0;
        if (cap_we) begin
            mem_wr.we = 1'h1;
            mem_wr.addr = cap_cnt_reg;
            mem_wr.data = {1'h1, cap_cnt_reg == 11'h000 || cap_cnt_reg == `SSP_PIX_SPLIT,
                PIXEL_IN.value};
        end else if (load_we) begin
            mem_wr.we = 1'h1;
            mem_wr.addr = load_cnt_reg;
            mem_wr.data = rx_byte_reg;
        end
    end

    // ------------------------------------------------------------
    // Firmware CRC self-test
    // ------------------------------------------------------------
    logic crc_rd_reg;
    logic [15:0] crc_val_reg;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            crc_busy_reg <= 1'h0;
            crc_rd_reg <= 1'h0;
            crc_ptr_reg <= 11'h000;
            crc_val_reg <= `SSP_CRC_INIT;
            data_out_reg <= 16'h0000;
        end else if (crc_start_reg) begin
            crc_busy_reg <= 1'h1;
            crc_rd_reg <= 1'h0;
            crc_ptr_reg <= 11'h000;
            crc_val_reg <= `SSP_CRC_INIT;
        end else if (crc_busy_reg) begin
            crc_rd_reg <= ~crc_rd_reg;
            if (crc_rd_reg) begin
                crc_val_reg <= crc16_byte(crc_val_reg, mem_rdata);
                crc_ptr_reg <= crc_ptr_reg + 11'h001;
                if (crc_ptr_reg == `SSP_FW_BYTES - 11'h001) begin
                    crc_busy_reg <= 1'h0;
                    data_out_reg <= crc16_byte(crc_val_reg, mem_rdata);
                end
            end
        end
    end

    pixel_store store_u (
        .clk_in(MCLK_IN),
        .wr_in(mem_wr),
        .raddr_in(crc_busy_reg ? crc_ptr_reg : pix_raddr_reg),
        .rdata_out(mem_rdata)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);

    AST_PORT_OFF_IDLE: assert property (port_off |=> state_reg == ssp_pkg::ST_IDLE && byte_idx_reg == 11'h000)
        else $error("port not idle after chip select rise");
    AST_CAPTURE_CAUSE: assert property ($rose(cap_wait_reg) |-> $past(state_reg) == ssp_pkg::ST_WDATA &&
        $past(take_byte) && $past(addr_reg) == `SSP_ADDR_FRAME_CAPTURE)
        else $error("capture armed without a completed write");
    AST_LOAD_LIMIT: assert property (load_cnt_reg <= `SSP_FW_BYTES)
        else $error("firmware byte count beyond image size");
    AST_BURST_HOLD: assert property ((state_reg inside {ssp_pkg::ST_MBURST, ssp_pkg::ST_PBURST,
        ssp_pkg::ST_LBURST}) && !port_off |=> state_reg == $past(state_reg))
        else $error("burst left without chip select");
    AST_UNMAPPED_ZERO: assert property (rd_addr && !(rx_byte_reg[6:0] inside {`SSP_ADDR_DATA_OUT_LO,
        `SSP_ADDR_DATA_OUT_HI, `SSP_ADDR_FW_VERSION, `SSP_ADDR_MOTION_BURST, `SSP_ADDR_PIXEL_BURST})
        |=> tx_word_reg == 8'h00 [*3])
        else $error("unmapped read not zero");
    AST_PIX_PAST_END: assert property (take_load && state_reg == ssp_pkg::ST_PBURST &&
        byte_idx_reg >= `SSP_PIX_BYTES |=> tx_word_reg == 8'h00 ##1 tx_word_reg == 8'h00)
        else $error("pixel read past end not zero");
    AST_MARKER: assert property (cap_we |-> mem_wr.data[7] &&
        mem_wr.data[6] == (cap_cnt_reg == 11'h000 || cap_cnt_reg == `SSP_PIX_SPLIT))
        else $error("pixel byte marker wrong");
    AST_TRACK_HALT: assert property (cap_hit |=> !tracking_reg && !fw_valid_reg)
        else $error("tracking not halted by capture");
    AST_MOTION_FIRST: assert property (rd_addr && rx_byte_reg[6:0] == `SSP_ADDR_MOTION_BURST
        |=> tx_word_reg == $past(MOTION_IN.motion) && state_reg == ssp_pkg::ST_MBURST)
        else $error("motion burst first byte wrong");

    COV_MOTION: cover property (state_reg == ssp_pkg::ST_MBURST && take_load);
    COV_LOAD_DONE: cover property (load_done);
    COV_CAPTURE: cover property ($rose(cap_ready_reg));
    COV_CRC: cover property ($fell(crc_busy_reg));
endmodule

// *** tb/spi_host.sv ***
// Host model: serial bus master for the sensor port
// Assumes the bench resolves MISO from the device enable
`timescale 1ns/100ps
module spi_host (
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    output logic stb_out,
    output logic [7:0] rx_out
);
    // ----------
    // Link tasks
    // ----------
    initial begin
        {sclk_out, cs_n_out, mosi_out, stb_out, rx_out} = 12'hC00;
    end
    task automatic sb(input logic [7:0] tx, input int n, input bit rd);
        for (int i = 7; i > 7 - n; i--) begin
            sclk_out = 1'b0;
            mosi_out = tx[i];
            #80;
            sclk_out = 1'b1;
            rx_out[i] = miso_in;
            #80;
        end
        stb_out = rd;
        #1 stb_out = 1'b0;
    endtask
    task automatic txn(input logic [7:0] a, input logic [7:0] d, input int nb, input int bits, input bit rd,
        input int gap);
        cs_n_out = 1'b0;
        #200;
        sb(a, 8, 1'b0);
        #200;
        repeat (nb) sb(d, bits, rd);
        cs_n_out = 1'b1;
        #(gap);
    endtask
endmodule

// *** tb/sensor_serial_port_burst_bench.sv ***
// Self-checking bench for the sensor serial port
// Assumes the host model in spi_host.sv
`timescale 1ns/100ps
module sensor_serial_port_burst_bench;
    // ----------
    // Stimulus and scoreboard
    // ----------
    localparam int EXIT_NS = 2000; // Burst exit kept short for run length
    logic clk = 1'b0, rstn = 1'b0, pd_n = 1'b1, srst = 1'b0;
    logic sclk, cs_n, mosi, miso, oe_n, stb, trk, fwv;
    logic [7:0] rx;
    logic [63:0] r64;
    logic [5:0] v0, v1;
    ssp_pkg::motion_s mot = '0;
    ssp_pkg::pixel_s pix = '0;
    logic [7:0] q[$];
    integer seed = 71, err_count = 0, cmp_count = 0;
    initial forever #5 clk = ~clk;
    sensor_serial_port_burst #(.FW_VERSION_ID(8'h5A)) i_dut (.MCLK_IN(clk), .RESETN_IN(rstn), .SCLK_IN(sclk),
        .CHIP_SELECT_N_IN(cs_n), .MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_N_OUT(oe_n), .POWER_DOWN_N_IN(pd_n),
        .SENSOR_RESET_IN(srst), .MOTION_IN(mot), .PIXEL_IN(pix), .TRACKING_EN_OUT(trk), .FW_VALID_OUT(fwv));
    spi_host i_host (.miso_in(oe_n ? ~miso : miso), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
        .stb_out(stb), .rx_out(rx));
    task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk(input string s, input logic e, input logic g);
        cmp(s, {7'h00, e}, {7'h00, g});
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge stb) begin
        cmp("miso byte", q.size() > 0 ? q.pop_front() : 8'hxx, rx);
    end
    initial begin
        #1000000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("tracking", 1'b1, trk);
        chk("fw valid", 1'b0, fwv);
        chk("miso oe", 1'b1, oe_n);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk) {pd_n, srst} = k ? 2'b11 : 2'b00;
            i_host.cs_n_out = 1'b0;
            #100 chk("miso oe", 1'b1, oe_n);
            i_host.cs_n_out = 1'b1;
            #1000;
        end
        @(negedge clk) {pd_n, srst} = 2'b10;
        done("pins");
        q.push_back(8'h5A);
        i_host.txn(8'h1F, 8'h00, 1, 8, 1, 1000);
        i_host.txn(8'hB0, 8'h55, 1, 8, 0, 50000);
        q.push_back(8'h00);
        i_host.txn(8'h30, 8'h00, 1, 8, 1, 1000);
        done("registers");
        r64 = {$random(seed), $random(seed)};
        @(negedge clk) mot = r64[55:0];
        for (int i = 6; i >= 0; i--) q.push_back(mot[8*i +: 8]);
        q.push_back(8'h00);
        fork
            i_host.txn(8'h50, 8'h00, 8, 8, 1, EXIT_NS);
            #3000 mot = ~mot;
        join
        done("motion burst");
        i_host.txn(8'h93, 8'h00, 1, 4, 0, 50000);
        chk("tracking", 1'b1, trk);
        i_host.txn(8'h93, 8'h00, 1, 8, 0, 50000);
        chk("tracking", 1'b0, trk);
        chk("fw valid", 1'b0, fwv);
        q.push_back(8'h00);
        i_host.txn(8'h40, 8'h00, 1, 8, 1, EXIT_NS);
        for (int i = 0; i < 1540; i++) begin
            r64 = {$random(seed), $random(seed)};
            @(negedge clk) pix = {1'b1, i == 0 || i == 900, r64[5:0]};
            if (i == 0) v0 = r64[5:0];
            if (i == 1) v1 = r64[5:0];
        end
        @(negedge clk) pix = '0;
        q.push_back({2'b11, v0});
        q.push_back({2'b10, v1});
        i_host.txn(8'h40, 8'h00, 2, 8, 1, EXIT_NS);
        done("capture");
        @(negedge clk) srst = 1'h1;
        repeat (4) @(negedge clk);
        srst = 1'h0;
        #1000;
        i_host.txn(8'h94, 8'h1D, 1, 8, 0, 50000);
        i_host.txn(8'h94, 8'h18, 1, 8, 0, 50000);
        i_host.txn(8'hE0, 8'hA5, 4, 8, 0, EXIT_NS);
        chk("tracking", 1'h0, trk);
        chk("fw valid", 1'h0, fwv);
        done("firmware");
        chk("queue empty", 1'b1, q.size() == 0);
        finish_test();
    end
endmodule
